// ---- shsc_consts.vh ----
// Purpose: Constants for the standby (light and deep) clock controller
// Assumes: Included by every design file of the block
// Notes:   Offsets are word addresses on the plain register port
`ifndef SHSC_CONSTS_VH
`define SHSC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SHSC_REG_CTRL        4'h0
`define SHSC_REG_STAB_SEL    4'h1
`define SHSC_REG_STATUS      4'h2
`define SHSC_REG_STAB_STAT   4'h3

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define SHSC_CTRL_RESET      8'h00
`define SHSC_CTRL_WD_RUN     0
`define SHSC_CTRL_WD_EN      4
`define SHSC_CTRL_LO_KEEP    6
`define SHSC_CTRL_LO_USE     7
`define SHSC_STAB_SEL_RESET  3'h7

// ----------------------------------------------------------------
// CPU clock source codes
// ----------------------------------------------------------------
`define SHSC_SRC_FAST        2'h0
`define SHSC_SRC_XTAL        2'h1
`define SHSC_SRC_EXT         2'h2
`define SHSC_SRC_SLOW        2'h3

// ----------------------------------------------------------------
// Wake wait counts in CPU clocks
// ----------------------------------------------------------------
`define SHSC_WAIT_VECT       4'hA
`define SHSC_WAIT_NEXT       4'h5

`endif

// ---- shsc_wake_wait.v ----
// Purpose: Counts the fixed wait between a wakeup and CPU restart
// Assumes: start_i is a one-cycle pulse from the standby sequencer
// Notes:   Wait length chosen by whether vectored servicing follows
`include "shsc_consts.vh"

module shsc_wake_wait (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       enable_i,
  input  wire       start_i,
  input  wire       vectored_i,
  output wire       busy_o,
  output wire       done_o
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  reg  [3:0] count_ff;    // Remaining wait cycles
  reg  [3:0] nxt_count;   // Next count

  // Load on start, count down to zero otherwise
  always @* begin
    nxt_count = count_ff;
    if (start_i) begin
      nxt_count = vectored_i ? `SHSC_WAIT_VECT : `SHSC_WAIT_NEXT;
    end else if (count_ff != 4'h0) begin
      nxt_count = count_ff - 4'h1;
    end
  end

  // Counter register, frozen while the enable is low
  always @(posedge clock_i) begin
    if (reset_i) begin
      count_ff <= 4'h0;
    end else if (enable_i) begin
      count_ff <= nxt_count;
    end
  end

  assign busy_o = (count_ff != 4'h0);
  assign done_o = (count_ff == 4'h1) & enable_i;

endmodule

// ---- shsc_stab_timer.v ----
// Purpose: Oscillation stabilization counter after deep standby release
// Assumes: Ticks once per crystal cycle seen as tick_i
// Notes:   Status bits fill from the lowest step upward and stay set until clear_i or reset
`include "shsc_consts.vh"

module shsc_stab_timer #(
  parameter CNT_W = 19
) (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       enable_i,
  input  wire       clear_i,
  input  wire       start_i,
  input  wire       tick_i,
  input  wire [2:0] select_i,
  output reg  [7:0] status_o,
  output wire       done_o
);

  // ----------------------------------------------------------------
  // Exponent of each step, lowest first
  // ----------------------------------------------------------------
  function [4:0] shsc_step_exp;
    input [2:0] idx;
    begin
      case (idx)
        3'd0:    shsc_step_exp = 5'd8;
        3'd1:    shsc_step_exp = 5'd9;
        3'd2:    shsc_step_exp = 5'd10;
        3'd3:    shsc_step_exp = 5'd11;
        3'd4:    shsc_step_exp = 5'd13;
        3'd5:    shsc_step_exp = 5'd15;
        3'd6:    shsc_step_exp = 5'd17;
        default: shsc_step_exp = 5'd18;
      endcase
    end
  endfunction

  reg  [CNT_W-1:0] count_ff;   // Elapsed ticks
  reg              run_ff;     // Counting in progress
  wire [7:0]       reached;    // Step thresholds passed
  wire             target;     // Selected step reached

  // Threshold compare per status step
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_step
      assign reached[g] = (count_ff >= ({{(CNT_W-1){1'b0}}, 1'b1} << shsc_step_exp(g[2:0])));
    end
  endgenerate

  assign target = reached[select_i];
  assign done_o = run_ff & target;

  // Counts only up to the selected time, then holds the status
  always @(posedge clock_i) begin
    if (reset_i) begin
      count_ff <= {CNT_W{1'b0}};
      run_ff   <= 1'b0;
      status_o <= 8'h00;
    end else if (enable_i) begin
      if (clear_i) begin
        count_ff <= {CNT_W{1'b0}};
        run_ff   <= 1'b0;
        status_o <= 8'h00;
      end else if (start_i) begin
        count_ff <= {CNT_W{1'b0}};
        run_ff   <= 1'b1;
      end else if (run_ff) begin
        if (target) begin
          run_ff <= 1'b0;
        end else if (tick_i) begin
          count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        status_o <= status_o | reached;
      end
    end
  end

endmodule

// ---- shsc_standby_ctrl.v ----
// Purpose: Standby sequencer gating CPU clock, oscillators and peripherals
// Assumes: halt_req_i and stop_req_i are one-cycle pulses from the CPU
// Notes:   Interrupt flags come from the interrupt controller's clock
`include "shsc_consts.vh"

module shsc_standby_ctrl #(
  parameter NUM_IRQ = 16,
  parameter CNT_W   = 19
) (
  input  wire               clock_i,
  input  wire               reset_i,
  input  wire               enable_i,
  input  wire               halt_req_i,
  input  wire               stop_req_i,
  input  wire [1:0]         cpu_src_i,
  input  wire               ack_enable_i,
  input  wire [NUM_IRQ-1:0] irq_flag_i,
  input  wire [NUM_IRQ-1:0] irq_mask_i,
  input  wire               xtal_tick_i,
  input  wire               fast_osc_run_i,
  input  wire               xtal_run_i,
  input  wire               ext_main_run_i,
  input  wire               slow_osc_run_i,
  input  wire               pll_run_i,
  input  wire [3:0]         reg_addr_i,
  input  wire [7:0]         reg_wdata_i,
  input  wire               reg_write_i,
  input  wire               reg_read_i,
  output reg  [7:0]         reg_rdata_o,
  output wire               cpu_clk_en_o,
  output wire               cpu_resume_o,
  output wire               cpu_vector_o,
  output reg                int_fast_osc_en_o,
  output reg                crystal_clk_en_o,
  output reg                ext_main_clk_en_o,
  output reg                int_slow_osc_en_o,
  output reg                pll_clk_en_o,
  output wire               ext_sub_clk_keep_o,
  output wire               flash_low_power_o,
  output wire               flash_stop_o,
  output wire               periph_run_o,
  output wire               dma_access_check_o,
  output wire               wdog_run_o,
  output wire               stop_refused_o,
  output wire               halted_o,
  output wire               stopped_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN  = 3'd0; // CPU clocked
  localparam [2:0] ST_HALT = 3'd1; // Light standby
  localparam [2:0] ST_STOP = 3'd2; // Deep standby
  localparam [2:0] ST_STAB = 3'd3; // Stabilization hold after stop
  localparam [2:0] ST_WAIT = 3'd4; // Fixed wake wait

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [2:0] state_ff;        // Sequencer state
  reg  [2:0] nxt_state;       // Next state
  reg  [7:0] ctrl_ff;         // Option-byte copy: watchdog, slow oscillator
  reg  [2:0] stab_sel_ff;     // Stabilization time select
  reg        was_stop_ff;     // Current standby began as deep standby
  reg        vect_ff;         // Vectored servicing will follow
  reg        refused_ff;      // Last stop refused for bad source
  reg  [4:0] pre_osc_ff;      // Pre-stop clocks
  reg  [NUM_IRQ-1:0] flag_s1_ff;  // Flag synchroniser, first stage
  reg  [NUM_IRQ-1:0] flag_s2_ff;  // Flag synchroniser, second stage
  reg  [NUM_IRQ-1:0] mask_s1_ff;  // Mask synchroniser, first stage
  reg  [NUM_IRQ-1:0] mask_s2_ff;  // Mask synchroniser, second stage
  reg        tick_s1_ff;      // Crystal tick synchroniser
  reg        tick_s2_ff;      // Crystal tick, second stage
  reg        tick_s3_ff;      // Delayed copy for edge detection

  wire       wake;            // Unmasked request pending
  wire       main_src;        // CPU on main system clock
  wire       stop_ok;         // Stop request accepted
  wire       wait_start;      // Launch the fixed wake wait
  wire       wait_busy;       // Wake wait running
  wire       wait_done;       // Wake wait ends this cycle
  wire       stab_start;      // Launch stabilization count
  wire       stab_done;       // Selected stabilization reached
  wire [7:0] stab_status;     // Stabilization counter status
  wire       xtal_tick;       // One pulse per rising crystal edge
  wire       lo_keep;         // Slow oscillator kept in deep standby

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Flags and masks come from another clock; two stages before use
  always @(posedge clock_i) begin
    if (reset_i) begin
      flag_s1_ff <= {NUM_IRQ{1'b0}};
      flag_s2_ff <= {NUM_IRQ{1'b0}};
      mask_s1_ff <= {NUM_IRQ{1'b1}};
      mask_s2_ff <= {NUM_IRQ{1'b1}};
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_s3_ff <= 1'b0;
    end else if (enable_i) begin
      flag_s1_ff <= irq_flag_i;
      flag_s2_ff <= flag_s1_ff;
      mask_s1_ff <= irq_mask_i;
      mask_s2_ff <= mask_s1_ff;
      tick_s1_ff <= xtal_tick_i;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wake      = |(flag_s2_ff & ~mask_s2_ff);
  assign xtal_tick = tick_s2_ff & ~tick_s3_ff;
  assign main_src  = (cpu_src_i != `SHSC_SRC_SLOW);
  assign stop_ok   = stop_req_i & main_src & (state_ff == ST_RUN);
  assign lo_keep   = ctrl_ff[`SHSC_CTRL_LO_KEEP] & ctrl_ff[`SHSC_CTRL_LO_USE];

  // Stabilization is started on deep-standby release by any unmasked request; reset release starts none
  assign stab_start = (state_ff == ST_STOP) & wake;
  // Wake wait follows halt release or end of stabilization
  assign wait_start = ((state_ff == ST_HALT) & wake) |
                      ((state_ff == ST_STAB) & stab_done);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next-state logic; reset (reset_i) always returns to run
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (stop_ok) begin
          // A pending request skips deep standby straight into the stabilization hold
          nxt_state = wake ? ST_STAB : ST_STOP;
        end else if (halt_req_i) begin
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (wake) begin
          nxt_state = ST_STAB;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // State register; reset ends any standby like a normal reset
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_ff    <= ST_RUN;
      was_stop_ff <= 1'b0;
      vect_ff     <= 1'b0;
      refused_ff  <= 1'b0;
    end else if (enable_i) begin
      state_ff <= nxt_state;
      if (stop_ok) begin
        was_stop_ff <= 1'b1;
      end else if (halt_req_i) begin
        was_stop_ff <= 1'b0;
      end
      // Acknowledge setting sampled when the wake is seen
      if (wake && (stop_ok || state_ff == ST_HALT || state_ff == ST_STOP)) begin
        vect_ff <= ack_enable_i;
      end
      if (stop_req_i) begin
        refused_ff <= ~main_src;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  // Captured on entry so light standby holds prior state exactly
  always @(posedge clock_i) begin
    if (reset_i) begin
      int_fast_osc_en_o <= 1'b1;
      crystal_clk_en_o  <= 1'b0;
      ext_main_clk_en_o <= 1'b0;
      int_slow_osc_en_o <= 1'b1;
      pll_clk_en_o      <= 1'b0;
    end else if (enable_i) begin
      if (state_ff == ST_RUN) begin
        if (stop_ok && !wake) begin
          int_fast_osc_en_o <= 1'b0;
          crystal_clk_en_o  <= 1'b0;
          ext_main_clk_en_o <= 1'b0;
          pll_clk_en_o      <= 1'b0;
          int_slow_osc_en_o <= slow_osc_run_i & lo_keep;
          pre_osc_ff <= {fast_osc_run_i, xtal_run_i, ext_main_run_i, slow_osc_run_i, pll_run_i};
        end else begin
          // Track what the clock generator runs; halt keeps it
          int_fast_osc_en_o <= fast_osc_run_i;
          crystal_clk_en_o  <= xtal_run_i;
          ext_main_clk_en_o <= ext_main_run_i;
          int_slow_osc_en_o <= slow_osc_run_i;
          pll_clk_en_o      <= pll_run_i;
        end
      end else if (state_ff == ST_STOP && wake) begin
        // Restore the pre-stop main clocks; PLL relocks by hardware
        int_fast_osc_en_o <= pre_osc_ff[4];
        crystal_clk_en_o  <= pre_osc_ff[3];
        ext_main_clk_en_o <= pre_osc_ff[2];
        int_slow_osc_en_o <= pre_osc_ff[1];
        pll_clk_en_o      <= pre_osc_ff[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Writes: option-byte copy and stabilization select
  always @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_ff     <= `SHSC_CTRL_RESET;
      stab_sel_ff <= `SHSC_STAB_SEL_RESET;
    end else if (enable_i && reg_write_i) begin
      if (reg_addr_i == `SHSC_REG_CTRL) begin
        ctrl_ff <= reg_wdata_i;
      end
      if (reg_addr_i == `SHSC_REG_STAB_SEL) begin
        stab_sel_ff <= reg_wdata_i[2:0];
      end
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero
  always @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (enable_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_read_i) begin
        case (reg_addr_i)
          `SHSC_REG_CTRL:      reg_rdata_o <= ctrl_ff;
          `SHSC_REG_STAB_SEL:  reg_rdata_o <= {5'h00, stab_sel_ff};
          `SHSC_REG_STATUS:    reg_rdata_o <= {3'h0, refused_ff, wake, state_ff};
          `SHSC_REG_STAB_STAT: reg_rdata_o <= stab_status;
          default:             reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  shsc_stab_timer #(
    .CNT_W    (CNT_W)
  ) u_stab (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (enable_i),
    .clear_i  (stop_ok & ~wake),
    .start_i  (stab_start | (stop_ok & wake)),
    .tick_i   (xtal_tick),
    .select_i (stab_sel_ff),
    .status_o (stab_status),
    .done_o   (stab_done)
  );

  shsc_wake_wait u_wait (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .enable_i   (enable_i),
    .start_i    (wait_start),
    .vectored_i ((state_ff == ST_HALT) ? ack_enable_i : vect_ff),
    .busy_o     (wait_busy),
    .done_o     (wait_done)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // CPU clock is gated in every standby state and during the wait
  assign cpu_clk_en_o       = (state_ff == ST_RUN);
  assign cpu_resume_o       = (state_ff == ST_WAIT) & wait_done;
  assign cpu_vector_o       = cpu_resume_o & vect_ff;
  assign ext_sub_clk_keep_o = 1'b1;
  // Flash stays usable at low current in light standby only
  assign flash_stop_o       = (state_ff == ST_STOP);
  assign flash_low_power_o  = (state_ff == ST_HALT);
  // Timers, serial, converter, DMA run unless in deep standby
  assign periph_run_o       = (state_ff != ST_STOP);
  assign dma_access_check_o = (state_ff != ST_STOP);
  // Watchdog keeps running in standby only if both bits allow it
  assign wdog_run_o = ctrl_ff[`SHSC_CTRL_WD_EN] &
                      (cpu_clk_en_o | ctrl_ff[`SHSC_CTRL_WD_RUN]);
  assign stop_refused_o     = refused_ff;
  assign halted_o           = (state_ff == ST_HALT) | (state_ff == ST_STAB) | wait_busy;
  assign stopped_o          = (state_ff == ST_STOP) & was_stop_ff;

endmodule

// ---- shsc_props.sv ----
// Purpose: Port assertions for the standby controller
// Assumes: One clock, synchronous active-high reset, enable held high
// Notes:   Bound onto the controller after the module
module shsc_props (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       halt_req_i,
  input wire logic       stop_req_i,
  input wire logic [1:0] cpu_src_i,
  input wire logic       ack_enable_i,
  input wire logic       cpu_clk_en_o,
  input wire logic       cpu_resume_o,
  input wire logic       cpu_vector_o,
  input wire logic       int_fast_osc_en_o,
  input wire logic       crystal_clk_en_o,
  input wire logic       pll_clk_en_o,
  input wire logic       flash_low_power_o,
  input wire logic       flash_stop_o,
  input wire logic       periph_run_o,
  input wire logic       dma_access_check_o,
  input wire logic       stop_refused_o,
  input wire logic       halted_o,
  input wire logic       stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Standby entry and exit checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Halt request seen while running
  sequence s_halt_req;
    cpu_clk_en_o && halt_req_i && !stop_req_i;
  endsequence
  // Gated core with flash in low-current mode
  sequence s_halted;
    !cpu_clk_en_o && halted_o && flash_low_power_o;
  endsequence
  a_halt_entry: assert property (
    s_halt_req |=> s_halted) else $error("halt request not taken");
  // Fast, crystal and PLL enables must not move while halted
  a_halt_keep: assert property (
    halted_o && $past(flash_low_power_o) && flash_low_power_o |->
    $stable({int_fast_osc_en_o, crystal_clk_en_o, pll_clk_en_o})) else $error("osc changed in halt");
  a_halt_periph: assert property (
    halted_o |-> periph_run_o && dma_access_check_o && !flash_stop_o) else $error("periph off in halt");
  a_stop_refuse: assert property (
    cpu_clk_en_o && stop_req_i && cpu_src_i == 2'h3 |=> cpu_clk_en_o && stop_refused_o && !stopped_o)
    else $error("stop from slow osc taken");
  // One cycle for the registered enables
  a_stop_osc: assert property (
    stopped_o && $past(stopped_o) |-> !int_fast_osc_en_o && !crystal_clk_en_o && !pll_clk_en_o &&
    flash_stop_o && !dma_access_check_o && !cpu_clk_en_o) else $error("clock left on in stop");
  a_resume_run: assert property (
    cpu_resume_o |=> cpu_clk_en_o && !halted_o) else $error("no run after resume");
  a_vector_ack: assert property (
    cpu_resume_o || cpu_vector_o |-> cpu_resume_o && (cpu_vector_o == ack_enable_i))
    else $error("vector does not follow ack");
  a_wait_min: assert property (
    cpu_resume_o |-> !$past(cpu_clk_en_o, 4) && (!cpu_vector_o || !$past(cpu_clk_en_o, 9)))
    else $error("wake wait too short");
  a_reset_run: assert property (disable iff (1'b0)
    reset_i |=> cpu_clk_en_o && !halted_o && !stopped_o && int_fast_osc_en_o)
    else $error("reset did not return to run");
endmodule

bind shsc_standby_ctrl shsc_props u_props (
  .clock_i(clock_i), .reset_i(reset_i), .halt_req_i(halt_req_i), .stop_req_i(stop_req_i),
  .cpu_src_i(cpu_src_i), .ack_enable_i(ack_enable_i), .cpu_clk_en_o(cpu_clk_en_o),
  .cpu_resume_o(cpu_resume_o), .cpu_vector_o(cpu_vector_o), .int_fast_osc_en_o(int_fast_osc_en_o),
  .crystal_clk_en_o(crystal_clk_en_o), .pll_clk_en_o(pll_clk_en_o), .flash_low_power_o(flash_low_power_o),
  .flash_stop_o(flash_stop_o), .periph_run_o(periph_run_o), .dma_access_check_o(dma_access_check_o),
  .stop_refused_o(stop_refused_o), .halted_o(halted_o), .stopped_o(stopped_o));

// ---- shsc_cpu_model.sv ----
// Purpose: Behavioural CPU core and interrupt controller
// Assumes: Bench calls one task at a time
// Notes:   Drives just after a rising edge
module shsc_cpu_model (
  input  wire logic        clock_i,
  output logic             halt_req_o,
  output logic             stop_req_o,
  output logic [1:0]       cpu_src_o,
  output logic             ack_enable_o,
  output logic [15:0]      irq_flag_o,
  output logic [15:0]      irq_mask_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle core on the fast oscillator, all masked
  initial begin
    halt_req_o   = 1'b0;
    stop_req_o   = 1'b0;
    cpu_src_o    = 2'h0;
    ack_enable_o = 1'b0;
    irq_flag_o   = 16'h0000;
    irq_mask_o   = 16'hFFFF;
  end
  // One standby instruction; source set on the same edge
  task automatic op(input logic stop, input logic [1:0] src, input logic ack);
    @(posedge clock_i);
    cpu_src_o    <= src;
    ack_enable_o <= ack;
    halt_req_o   <= !stop;
    stop_req_o   <= stop;
    @(posedge clock_i);
    halt_req_o   <= 1'b0;
    stop_req_o   <= 1'b0;
  endtask
  // Raise one request flag, masked or not
  task automatic set_irq(input int idx, input logic masked);
    @(posedge clock_i);
    irq_flag_o[idx] <= 1'b1;
    irq_mask_o[idx] <= masked;
  endtask
  // Service done; clears every flag and masks all requests again
  task automatic clr_irq;
    @(posedge clock_i);
    irq_flag_o <= 16'h0000;
    irq_mask_o <= 16'hFFFF;
  endtask
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the standby controller
// Assumes: Crystal tick free-running, unrelated to clock
// Notes:   Stabilization select 0 keeps the deep wake short
`include "shsc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i   = 1'b0;
  logic        reset_i   = 1'b1;
  logic        enable_i  = 1'b1;
  logic        xtal_tick = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  int          failures  = 0;
  int          cmp_count = 0;
  wire  [15:0] irq_flag, irq_mask;
  wire  [7:0]  rdata;
  wire  [1:0]  src;
  wire         halt_req, stop_req, ack, clk_en, resume, vector, wdog;
  wire         fast_en, xtal_en, ext_en, slow_en, pll_en, refused, halted, stopped;

  always #12.5 clock_i = ~clock_i;
  always #30 xtal_tick = ~xtal_tick;

  shsc_cpu_model u_cpu (.clock_i(clock_i), .halt_req_o(halt_req), .stop_req_o(stop_req),
    .cpu_src_o(src), .ack_enable_o(ack), .irq_flag_o(irq_flag), .irq_mask_o(irq_mask));
  // Run inputs follow the enables
  shsc_standby_ctrl u_dut (.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
    .halt_req_i(halt_req), .stop_req_i(stop_req), .cpu_src_i(src), .ack_enable_i(ack),
    .irq_flag_i(irq_flag), .irq_mask_i(irq_mask), .xtal_tick_i(xtal_tick), .fast_osc_run_i(fast_en),
    .xtal_run_i(xtal_en), .ext_main_run_i(ext_en), .slow_osc_run_i(slow_en), .pll_run_i(pll_en),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(rdata), .cpu_clk_en_o(clk_en), .cpu_resume_o(resume), .cpu_vector_o(vector),
    .int_fast_osc_en_o(fast_en), .crystal_clk_en_o(xtal_en), .ext_main_clk_en_o(ext_en),
    .int_slow_osc_en_o(slow_en), .pll_clk_en_o(pll_en), .ext_sub_clk_keep_o(), .flash_low_power_o(),
    .flash_stop_o(), .periph_run_o(), .dma_access_check_o(), .wdog_run_o(wdog),
    .stop_refused_o(refused), .halted_o(halted), .stopped_o(stopped));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tmo(input string what);
    failures++;
    $display("mismatch %s exp done got timeout", what);
    give_verdict;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_i);
    reg_write <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_i);
    reg_read <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for resume, n counts cycles
  task automatic wait_resume(input string what, output int n);
    for (n = 1; n < 2000 && resume !== 1'b1; n++) @(posedge clock_i) #1;
    if (n == 2000) tmo(what);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    rd(`SHSC_REG_CTRL, d);
    chk("ctrl reset", `SHSC_CTRL_RESET, d);
    rd(`SHSC_REG_STAB_SEL, d);
    chk("select reset", {5'h00, `SHSC_STAB_SEL_RESET}, d);
    wr(`SHSC_REG_STATUS, 8'hFF);
    rd(`SHSC_REG_STATUS, d);
    chk("status read only", 8'h00, d);
    rd(4'hF, d);
    chk("unmapped", 8'h00, d);
    chk("osc reset", 8'h11, {3'h0, fast_en, xtal_en, ext_en, pll_en, slow_en});
    $display("test regs done");
  endtask
  // Every source, both ack levels; masked flag must not wake
  task automatic t_halt;
    int n;
    for (int i = 0; i < 8; i++) begin
      wr(`SHSC_REG_CTRL, i[0] ? 8'h11 : 8'h10);
      u_cpu.op(1'b0, i[1:0], i[2]);
      #1 chk("halted", 8'h01, {7'h00, halted & ~clk_en});
      chk("wdog", {7'h00, i[0]}, {7'h00, wdog});
      u_cpu.set_irq(3, 1'b1);
      repeat (8) @(posedge clock_i);
      #1 chk("masked", 8'h01, {7'h00, halted});
      u_cpu.set_irq(3, 1'b0);
      repeat (3) @(posedge clock_i);
      #1 wait_resume("halt wake", n);
      chk("wait", i[2] ? `SHSC_WAIT_VECT : `SHSC_WAIT_NEXT, n[7:0]);
      chk("vector", {7'h00, i[2]}, {7'h00, vector});
      @(posedge clock_i) #1 chk("run", 8'h01, {7'h00, clk_en});
      u_cpu.clr_irq;
    end
    $display("test halt done");
  endtask
  task automatic t_stop;
    int n;
    logic [7:0] d;
    wr(`SHSC_REG_STAB_SEL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(`SHSC_REG_CTRL, i[0] ? 8'hC0 : 8'h40);
      u_cpu.op(1'b1, 2'h1, 1'b1);
      #1 chk("stopped", 8'h01, {7'h00, stopped});
      @(posedge clock_i) #1 chk("slow osc", {7'h00, i[0]}, {7'h00, slow_en});
      u_cpu.set_irq(5, 1'b0);
      wait_resume("stop wake", n);
      chk("stab wait", 8'h01, {7'h00, n > 600});
      rd(`SHSC_REG_STAB_STAT, d);
      chk("stab status", 8'h01, d);
      u_cpu.clr_irq;
    end
    u_cpu.set_irq(2, 1'b0);
    repeat (3) @(posedge clock_i);
    u_cpu.op(1'b1, 2'h0, 1'b0);
    #1 chk("pending", 8'h00, {6'h00, stopped, clk_en});
    wait_resume("pending wake", n);
    u_cpu.clr_irq;
    u_cpu.op(1'b1, 2'h3, 1'b0);
    #1 chk("refused", 8'h03, {6'h00, refused, clk_en});
    rd(`SHSC_REG_STATUS, d);
    chk("status", 8'h10, d);
    $display("test stop done");
  endtask
  task automatic t_rst_halt;
    logic [7:0] d;
    wr(`SHSC_REG_CTRL, 8'hC1);
    u_cpu.op(1'b0, 2'h1, 1'b0);
    @(posedge clock_i) reset_i <= 1'b1;
    @(posedge clock_i) reset_i <= 1'b0;
    #1 chk("reset run", 8'h01, {7'h00, clk_en & ~halted});
    rd(`SHSC_REG_CTRL, d);
    chk("reset ctrl", `SHSC_CTRL_RESET, d);
    $display("test reset done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    t_regs;
    t_halt;
    t_stop;
    t_rst_halt;
    give_verdict;
  end
endmodule
